// File: logic/serial_flash_spi_slave.sv
// Device-side serial interface and write control of a serial flash
`timescale 1ns/1ps

// How it works
// [RQ1] Data-out shifts on serial clock falling edge
// [RQ2] Data-in sampled on serial clock rising edge
// [RQ3] Deselected means data-out released, high impedance
// [RQ4] No command before first select falling edge
// [RQ5] Pause tri-states output, ignores clock and data
// [RQ6] Host keeps select low throughout a pause
// [RQ7] Protect pin low blocks writes to guarded area
// [RQ8] Modes 0 and 3 both work
// [RQ9] Mode 0 host idles clock low
// [RQ10] Mode 3 host idles clock high
// [RQ11] Everything moves in whole eight-bit bytes
// [RQ12] Host unlocks, then sends page write frame
// [RQ13] Page write takes one to 256 bytes
// [RQ14] Programming only clears bits, never sets
// [RQ15] Host erases target bytes before programming
// [RQ16] Region clear and whole-array clear set ones
// [RQ17] Busy flag readable by status read, polled
// [RQ18] Active until internal operation ends, then standby
// [RQ19] Deep sleep ignores program and erase commands
// [RQ20] Unlock sets latch; completions and lock clear
// [RQ21] Opcode byte first, MSB first, after select
// [RQ22] Pause starts with clock low or next fall
// [RQ23] Busy lasts a configurable number of cycles
// [RQ24] Select rising mid-command abandons the command
module serial_flash_spi_slave
  import flash_pkg::*;
#(
  parameter logic [23:0] PROG_CYCLES = PROG_CYC_DEF,
  parameter logic [23:0] SECT_CYCLES = SECT_CYC_DEF,
  parameter logic [23:0] ALL_CYCLES  = ALL_CYC_DEF,
  parameter logic [23:0] STAT_CYCLES = STAT_CYC_DEF
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              si,
  input  wire logic              hold_n,
  input  wire logic              wp_n,
  output logic                   so,
  output logic                   so_oe,
  output logic                   busy_flag,
  output logic                   write_enable_latch,
  output logic [2:0]             protect_level_bits,
  output logic                   deep_sleep,
  output logic                   active_mode,
  output logic                   pc_clear,
  output logic                   pc_valid,
  input  wire logic              pc_ready,
  output logic [ADDR_W-1:0]      pc_addr,
  output logic [7:0]             pc_data,
  input  wire logic [7:0]        pc_old,
  output logic                   op_start,
  output logic [1:0]             op_kind,
  output logic [ADDR_W-1:0]      op_addr
);

  // Filtered pin levels
  logic [4:0]        pins_f;
  logic              cs_f;          // Select, low active
  logic              sck_f;         // Serial clock
  logic              si_f;          // Serial data in
  logic              hold_f;        // Pause, low active
  logic              wp_f;          // Protect pin, low active

  // Edge history
  logic              cs_d_r;
  logic              sck_d_r;
  logic              cs_fall;
  logic              cs_rise;
  logic              sck_rise;
  logic              sck_fall;

  // Link control
  link_state_t       link_r;
  logic              pause_start;   // Pause begins this cycle
  logic              pause_end;     // Pause ends this cycle
  logic              rx_edge;       // Sampling edge that counts
  logic              tx_edge;       // Launch edge that counts

  // Receive path
  logic [6:0]        sh_r;          // Bits of the byte so far
  logic [2:0]        bit_cnt_r;     // Bits within current byte
  logic [8:0]        byte_cnt_r;    // Whole bytes this frame
  logic [7:0]        rx_byte;       // Byte completed at this edge
  logic              byte_done;
  logic [7:0]        opcode_r;
  logic [23:0]       addr_r;
  logic [2:0]        pend_bp_r;     // Protect level awaiting commit
  logic [7:0]        col_r;         // Column of next page byte
  logic              overrun_r;     // Buffer refused a page byte

  // Transmit path
  logic [7:0]        tx_r;
  logic [7:0]        cur_op;        // Opcode in force for this byte
  logic [7:0]        status_byte;

  // Page byte buffer
  logic              buf_push;
  logic              buf_in_ready;
  logic [15:0]       buf_out;

  // Internal operation control
  busy_state_t       busy_r;
  logic [BUSY_W-1:0] cnt_r;
  logic              frame_ok;      // Frame ended whole and idle
  logic              wr_ok;         // Latch set and awake
  logic              prot_sect;     // Target sector guarded
  logic              go_unlock;
  logic              go_lock;
  logic              go_stat;
  logic              go_page;
  logic              go_sect;
  logic              go_all;
  logic              go_sleep;
  logic              go_wake;
  logic              go_any;

  // Asynchronous pins pass the three-stage filter
  pin_sync #(
    .W       (5),
    .RST_VAL (PINS_RESET)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({wp_n, hold_n, si, sck, cs_n}),
    .dout  (pins_f)
  );

  assign cs_f   = pins_f[0];
  assign sck_f  = pins_f[1];
  assign si_f   = pins_f[2];
  assign hold_f = pins_f[3];
  assign wp_f   = pins_f[4];

  // Previous filtered levels for edge finding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cs_d_r  <= cs_f;
      sck_d_r <= sck_f;
    end
  end

  assign cs_fall  = cs_d_r && !cs_f;
  assign cs_rise  = !cs_d_r && cs_f;
  assign sck_rise = !sck_d_r && sck_f;
  assign sck_fall = sck_d_r && !sck_f;

  // Pause waits for a low clock or the next falling clock edge
  assign pause_start = !hold_f && (!sck_f || sck_fall);      // [RQ22]
  assign pause_end   = hold_f && (!sck_f || sck_fall);

  // Edges count only while selected and unpaused
  assign rx_edge = (link_r == L_XFER) && sck_rise;           // [RQ2] [RQ8]
  assign tx_edge = (link_r == L_XFER) && sck_fall && !pause_start;  // [RQ1] [RQ8]

  // Link state; a select rise always drops back to idle, even in pause
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_r <= L_LOCKED;
    end else begin
      unique case (link_r)
        L_LOCKED: begin
          if (cs_fall) begin                                 // [RQ4]
            link_r <= L_XFER;
          end
        end
        L_IDLE: begin
          if (cs_fall) begin
            link_r <= L_XFER;
          end
        end
        L_XFER: begin
          if (cs_rise) begin
            link_r <= L_IDLE;
          end else if (pause_start) begin                    // [RQ5]
            link_r <= L_PAUSE;
          end
        end
        L_PAUSE: begin
          if (cs_rise) begin
            link_r <= L_IDLE;
          end else if (pause_end) begin
            link_r <= L_XFER;
          end
        end
      endcase
    end
  end

  assign rx_byte   = {sh_r, si_f};
  assign byte_done = rx_edge && (bit_cnt_r == 3'h7);        // [RQ11]
  assign cur_op    = (byte_cnt_r == 9'h000) ? rx_byte : opcode_r;

  // Bit and byte counting; any select edge restarts the frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_r       <= 7'h00;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 9'h000;
    end else if (cs_rise || cs_fall) begin                   // [RQ24]
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 9'h000;
    end else if (rx_edge) begin
      sh_r      <= rx_byte[6:0];                             // [RQ21]
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done && (byte_cnt_r != LEN_SATURATE)) begin
        byte_cnt_r <= byte_cnt_r + 9'h001;
      end
    end
  end

  // Opcode, address and status operand capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opcode_r  <= 8'h00;
      addr_r    <= 24'h00_0000;
      pend_bp_r <= BP_RESET;
    end else if (byte_done) begin
      if (byte_cnt_r == 9'h000) begin                        // [RQ21]
        opcode_r <= rx_byte;
      end
      if ((byte_cnt_r >= 9'h001) && (byte_cnt_r <= 9'h003)) begin
        addr_r <= {addr_r[15:0], rx_byte};
      end
      if ((byte_cnt_r == 9'h001) && (opcode_r == CMD_WRITE_STATUS)) begin
        pend_bp_r <= rx_byte[STAT_BP_LSB +: 3];
      end
    end
  end

  // Page bytes go to the buffer tagged with their column
  assign buf_push = byte_done && (byte_cnt_r >= 9'h004) &&
                    (opcode_r == CMD_PAGE_WRITE) && (busy_r == B_IDLE);

  // Column walk wraps inside the page, so byte 257 lands on the column of byte 1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      col_r     <= 8'h00;
      overrun_r <= 1'b0;
      pc_clear  <= 1'b0;
    end else begin
      pc_clear <= 1'b0;
      if (cs_fall) begin
        overrun_r <= 1'b0;
      end else if (buf_push && !buf_in_ready) begin
        overrun_r <= 1'b1;                    // Lost byte voids the frame
      end
      if (byte_done && (byte_cnt_r == 9'h003)) begin
        col_r    <= rx_byte;
        pc_clear <= (opcode_r == CMD_PAGE_WRITE) && (busy_r == B_IDLE);
      end else if (buf_push) begin
        col_r <= col_r + 8'h01;                              // [RQ13]
      end
    end
  end

  // Two-entry buffer absorbs back-end stalls between serial bytes
  pair_buf #(
    .W     (16),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   ({col_r, rx_byte}),
    .out_valid (pc_valid),
    .out_ready (pc_ready),
    .out_data  (buf_out)
  );

  assign pc_addr = {addr_r[ADDR_W-1:PAGE_LSB], buf_out[15:8]};
  // Merge with the stored byte so a zero never returns to one
  assign pc_data = buf_out[7:0] & pc_old;                    // [RQ14]

  // Status byte shows live busy, latch and protect level
  always_comb begin
    status_byte                           = 8'h00;
    status_byte[STAT_BUSY_POS]            = busy_flag;       // [RQ17]
    status_byte[STAT_WEL_POS]             = write_enable_latch;
    status_byte[STAT_BP_LSB +: 3]         = protect_level_bits;
  end

  // Output shifter; status repeats while clocked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_r <= 8'h00;
      so   <= 1'b0;
    end else if (cs_fall) begin
      tx_r <= 8'h00;
    end else if (byte_done) begin
      tx_r <= (cur_op == CMD_READ_STATUS) ? status_byte : 8'h00;  // [RQ17]
    end else if (tx_edge) begin
      so   <= tx_r[7];                                       // [RQ1]
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // Driven only while selected and not paused
  assign so_oe = (link_r == L_XFER);                         // [RQ3] [RQ5]

  // Frame qualifiers at select rise; partial bytes never commit
  assign frame_ok  = cs_rise && (link_r == L_XFER) && (bit_cnt_r == 3'h0) &&
                     (busy_r == B_IDLE);                     // [RQ24] [RQ11]
  assign wr_ok     = write_enable_latch && !deep_sleep;      // [RQ19]
  assign prot_sect = !wp_f && prot_hit(addr_r[SECT_LSB +: 5], protect_level_bits);

  assign go_unlock = frame_ok && (opcode_r == CMD_WRITE_UNLOCK) && (byte_cnt_r == LEN_ONE_BYTE);
  assign go_lock   = frame_ok && (opcode_r == CMD_WRITE_LOCK) && (byte_cnt_r == LEN_ONE_BYTE);
  assign go_stat   = frame_ok && (opcode_r == CMD_WRITE_STATUS) &&
                     (byte_cnt_r == LEN_STATUS_WR) && write_enable_latch;
  assign go_page   = frame_ok && (opcode_r == CMD_PAGE_WRITE) && wr_ok &&
                     (byte_cnt_r >= LEN_PAGE_MIN) && !overrun_r && !prot_sect;  // [RQ7] [RQ13]
  assign go_sect   = frame_ok && (opcode_r == CMD_REGION_CLEAR) && wr_ok &&
                     (byte_cnt_r == LEN_REGION) && !prot_sect;                  // [RQ7]
  assign go_all    = frame_ok && (opcode_r == CMD_WHOLE_ARRAY_CLEAR) && wr_ok &&
                     (byte_cnt_r == LEN_ONE_BYTE) &&
                     (wp_f || (protect_level_bits == BP_RESET));                // [RQ7]
  assign go_sleep  = frame_ok && (opcode_r == CMD_DEEP_SLEEP) && (byte_cnt_r == LEN_ONE_BYTE);
  assign go_wake   = frame_ok && (opcode_r == CMD_WAKE) && (byte_cnt_r == LEN_ONE_BYTE);
  assign go_any    = go_stat || go_page || go_sect || go_all;

  // Busy sequencing with a cycle count per kind of operation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= B_IDLE;
      cnt_r  <= '0;
    end else begin
      unique case (busy_r)
        B_IDLE: begin
          if (go_any) begin
            busy_r <= B_RUN;                                 // [RQ23]
            if (go_page) begin
              cnt_r <= PROG_CYCLES;
            end else if (go_sect) begin
              cnt_r <= SECT_CYCLES;
            end else if (go_all) begin
              cnt_r <= ALL_CYCLES;
            end else begin
              cnt_r <= STAT_CYCLES;
            end
          end
        end
        B_RUN: begin
          if (cnt_r <= 24'h00_0001) begin
            busy_r <= B_IDLE;
          end else begin
            cnt_r <= cnt_r - 24'h00_0001;
          end
        end
      endcase
    end
  end

  // Array operation request to the storage back end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_start <= 1'b0;
      op_kind  <= OP_PROGRAM;
      op_addr  <= '0;
    end else begin
      op_start <= go_page || go_sect || go_all;
      if (go_page || go_sect || go_all) begin
        op_addr <= addr_r[ADDR_W-1:0];
        op_kind <= go_page ? OP_PROGRAM : (go_sect ? OP_SECTOR : OP_ARRAY);  // [RQ16]
      end
    end
  end

  // Write latch; cleared on completion or lock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;                            // [RQ20]
    end else if (go_unlock) begin
      write_enable_latch <= 1'b1;                            // [RQ20]
    end else if (go_lock || ((busy_r == B_RUN) && (cnt_r <= 24'h00_0001))) begin
      write_enable_latch <= 1'b0;                            // [RQ20]
    end
  end

  // Protect level takes the new value as the status write starts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      protect_level_bits <= BP_RESET;
    end else if (go_stat) begin
      protect_level_bits <= pend_bp_r;
    end
  end

  // Deep sleep; the wake command is the only way out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      deep_sleep <= 1'b0;
    end else if (go_sleep) begin
      deep_sleep <= 1'b1;                                    // [RQ19]
    end else if (go_wake) begin
      deep_sleep <= 1'b0;
    end
  end

  // Busy flag and power mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_flag   <= 1'b0;
      active_mode <= 1'b0;
    end else begin
      busy_flag   <= go_any || ((busy_r == B_RUN) && (cnt_r > 24'h00_0001));    // [RQ17]
      active_mode <= !cs_f || go_any || (busy_r == B_RUN);   // [RQ18]
    end
  end

endmodule : serial_flash_spi_slave

// File: common/flash_pkg.sv
// Shared constants, types and helpers of the serial flash interface block
package flash_pkg;

  // Opcode values of the command set
  localparam logic [7:0] CMD_WRITE_UNLOCK      = 8'h10;
  localparam logic [7:0] CMD_WRITE_LOCK        = 8'h11;
  localparam logic [7:0] CMD_READ_STATUS       = 8'h12;
  localparam logic [7:0] CMD_WRITE_STATUS      = 8'h13;
  localparam logic [7:0] CMD_PAGE_WRITE        = 8'h15;
  localparam logic [7:0] CMD_REGION_CLEAR      = 8'h16;
  localparam logic [7:0] CMD_WHOLE_ARRAY_CLEAR = 8'h17;
  localparam logic [7:0] CMD_DEEP_SLEEP        = 8'h18;
  localparam logic [7:0] CMD_WAKE              = 8'h19;

  // Byte counts of complete command frames
  localparam logic [8:0] LEN_ONE_BYTE   = 9'h001;
  localparam logic [8:0] LEN_STATUS_WR  = 9'h002;
  localparam logic [8:0] LEN_REGION     = 9'h004;
  localparam logic [8:0] LEN_PAGE_MIN   = 9'h005;
  localparam logic [8:0] LEN_SATURATE   = 9'h1FF;

  // Status byte field positions
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_WEL_POS  = 1;
  localparam int STAT_BP_LSB   = 2;

  // Address field positions
  localparam int ADDR_W        = 21;
  localparam int SECT_LSB      = 16;
  localparam int PAGE_LSB      = 8;

  // Values after reset
  localparam logic [2:0] BP_RESET   = 3'h0;
  localparam logic [4:0] PINS_RESET = 5'h1D;

  // Default busy durations in clock cycles
  localparam int         BUSY_W        = 24;
  localparam logic [23:0] PROG_CYC_DEF  = 24'h00_1000;
  localparam logic [23:0] SECT_CYC_DEF  = 24'h00_8000;
  localparam logic [23:0] ALL_CYC_DEF   = 24'h01_0000;
  localparam logic [23:0] STAT_CYC_DEF  = 24'h00_0800;

  // Kinds of array operation handed to the storage back end
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_SECTOR  = 2'h2;
  localparam logic [1:0] OP_ARRAY   = 2'h3;

  // Serial link states
  typedef enum logic [3:0] {
    L_LOCKED = 4'h1,
    L_IDLE   = 4'h2,
    L_XFER   = 4'h4,
    L_PAUSE  = 4'h8
  } link_state_t;

  // Internal operation states
  typedef enum logic [1:0] {
    B_IDLE = 2'h1,
    B_RUN  = 2'h2
  } busy_state_t;

  // True when a sector falls in the area guarded by the protect level
  function automatic logic prot_hit(input logic [4:0] sect, input logic [2:0] bp);
    logic hit;
    hit = 1'b0;
    case (bp)
      3'h0: hit = 1'b0;
      3'h1: hit = (sect >= 5'h1F);
      3'h2: hit = (sect >= 5'h1E);
      3'h3: hit = (sect >= 5'h1C);
      3'h4: hit = (sect >= 5'h18);
      3'h5: hit = (sect >= 5'h10);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction : prot_hit

endpackage : flash_pkg

// File: logic/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;  // First stage, read only by s2_r
  logic [W-1:0] s2_r;  // Second stage
  logic [W-1:0] s3_r;  // Third stage

  // Plain shift chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout <= RST_VAL;
    end else begin
      dout <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & dout);
    end
  end

endmodule : pin_sync

// File: logic/pair_buf.sv
// Small valid/ready buffer built from flip-flops
`timescale 1ns/1ps
module pair_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];  // Storage entries
  logic [AW-1:0] wr_ptr_r;       // Next slot to fill
  logic [AW-1:0] rd_ptr_r;       // Oldest slot
  logic [AW:0]   cnt_r;          // Entries held
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage needs no reset; empty slots are never shown
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule : pair_buf

// File: verif/flash_chk_sva.sv
// Port-level assertions for the serial flash interface block
`timescale 1ns/1ps
module flash_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        hold_n,
  input wire logic        wp_n,
  input wire logic        so_oe,
  input wire logic        busy_flag,
  input wire logic        write_enable_latch,
  input wire logic [2:0]  protect_level_bits,
  input wire logic        deep_sleep,
  input wire logic        active_mode,
  input wire logic        pc_valid,
  input wire logic        pc_ready,
  input wire logic [20:0] pc_addr,
  input wire logic [7:0]  pc_data,
  input wire logic [7:0]  pc_old,
  input wire logic        op_start,
  input wire logic [20:0] op_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Pins lag ~4 clk; 8 steady samples leave margin
  property p_desel; cs_n [*8] |-> !so_oe; endproperty
  a_desel: assert property (p_desel) else $error("so on, deselected");
  property p_pause; (!hold_n && !cs_n && !sck) [*8] |-> !so_oe; endproperty
  a_pause: assert property (p_pause) else $error("so on, paused");
  property p_busy; op_start |-> ##[0:1] busy_flag; endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  property p_wel; op_start |-> write_enable_latch; endproperty
  a_wel: assert property (p_wel) else $error("no latch");
  property p_sleep; op_start |-> !deep_sleep; endproperty
  a_sleep: assert property (p_sleep) else $error("op asleep");
  property p_clr; $fell(busy_flag) |-> ##[0:1] !write_enable_latch; endproperty
  a_clr: assert property (p_clr) else $error("latch kept");
  property p_act; busy_flag |-> active_mode; endproperty
  a_act: assert property (p_act) else $error("standby busy");
  property p_stby; (cs_n && !busy_flag) [*8] |-> !active_mode; endproperty
  a_stby: assert property (p_stby) else $error("active idle");
  property p_prot; op_start && !wp_n && protect_level_bits == 3'h1 |-> op_addr[20:16] != 5'h1f;
  endproperty
  a_prot: assert property (p_prot) else $error("guarded hit");
  property p_stall; pc_valid && !pc_ready |=> pc_valid && $stable(pc_addr); endproperty
  a_stall: assert property (p_stall) else $error("byte lost");
  property p_mask; pc_valid |-> (pc_data & ~pc_old) == 8'h00; endproperty
  a_mask: assert property (p_mask) else $error("bit set");
  property p_len; $rose(busy_flag) |-> busy_flag [*8]; endproperty
  a_len: assert property (p_len) else $error("busy short");
endmodule : flash_chk

bind serial_flash_spi_slave flash_chk u_chk (.*);

// File: verif/flash_host.sv
// Serial bus master model driving the flash pins
`timescale 1ns/1ps
module flash_host (
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n
);
  logic       mode3 = 1'b0;  // Idle clock level
  logic [7:0] tx_q[$];       // Bytes to send
  logic [7:0] rx_q[$];       // Bytes seen on data out
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  // Half a serial clock period: 4 clk
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half
  // One frame; cut stops after that many bits
  task automatic frame(input int cut, input bit pause);
    logic [7:0] b, r;
    int nb;
    nb = 0;
    sck = mode3;
    cs_n = 1'b0;
    half();
    while (tx_q.size() != 0 && nb != cut) begin
      b = tx_q.pop_front();
      for (int i = 7; i >= 0 && nb != cut; i--) begin
        sck = 1'b0;
        si = b[i];
        // Pause in byte two at clock low, select low
        if (pause && nb == 8) begin
          hold_n = 1'b0;
          repeat (16) @(negedge clk);
          hold_n = 1'b1;
        end
        half();
        sck = 1'b1;
        // Sample late; output lags the clock
        repeat (2) @(negedge clk);
        r = {r[6:0], so};
        repeat (2) @(negedge clk);
        nb++;
      end
      rx_q.push_back(r);
    end
    if (!mode3) sck = 1'b0;
    half();
    cs_n = 1'b1;
    si = ~si; // Released line shows no stale value
    tx_q = {};
    repeat (8) @(negedge clk);
  endtask : frame
endmodule : flash_host

// File: verif/testbench.sv
// Self-checking bench for the serial flash interface block
`timescale 1ns/1ps
module testbench;
  import flash_pkg::*;
  logic clk, rst_n, wp_n, pc_ready, cs_n, sck, si, hold_n, so, so_oe, busy_flag;
  logic write_enable_latch, deep_sleep, active_mode, pc_clear, pc_valid, op_start;
  logic [2:0] protect_level_bits, m_lvl = 3'h0;
  logic [1:0] op_kind, k_last = 2'h0;
  logic [20:0] pc_addr, op_addr;
  logic [7:0] pc_data, pc_old, st, seed = 8'h45, dat = 8'h45, col = 8'h00, n_ops = 8'h00;
  logic m_wel = 1'b0;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int checked = 0;
  wire so_pin;
  assign so_pin = so_oe ? so : 1'bz;
  assign pc_old = pc_addr[7:0] ^ 8'h5a; // Back end array content
  localparam logic [23:0] CY = 24'h00_0032;  // Short busy spans
  serial_flash_spi_slave #(.PROG_CYCLES(CY), .SECT_CYCLES(CY), .ALL_CYCLES(CY),
    .STAT_CYCLES(CY)) DUT (.*);
  flash_host host (.clk, .so(so_pin), .cs_n, .sck, .si, .hold_n);
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Random back end stalls
  always @(negedge clk) begin
    seed <= lfsr(seed);
    pc_ready <= seed[0];
  end
  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      n_ops <= n_ops + 8'h01;
      k_last <= op_kind;
    end
    if (pc_valid === 1'b1 && pc_ready === 1'b1) begin
      check(pc_data, exp_q.pop_front() & (col ^ 8'h5a));
      check(pc_addr[7:0], col);
      col <= col + 8'h01;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  // Opcode, argument bytes, random page bytes
  task automatic cmd(input logic [7:0] op, input logic [23:0] arg, input int n,
                     input int nd = 0, input int cut = 999);
    host.tx_q.push_back(op);
    for (int i = 0; i < n - 1; i++) host.tx_q.push_back(arg[23 - 8 * i -: 8]);
    col = arg[7:0];
    for (int i = 0; i < nd; i++) begin
      dat = lfsr(dat);
      host.tx_q.push_back(dat);
      exp_q.push_back(dat);
    end
    host.frame(cut, nd > 0);
  endtask : cmd
  task automatic rd();
    host.rx_q = {};
    cmd(CMD_READ_STATUS, 24'h00_0000, 2);
    st = host.rx_q[1];
  endtask : rd
  task automatic status();
    rd();
    check(st, {3'h0, m_lvl, m_wel, 1'b0});
  endtask : status
  // Busy at the pin, then polled
  task automatic idle();
    int i;
    check(busy_flag, 8'h01);
    i = 0;
    do rd(); while (st[0] !== 1'b0 && ++i < 10);
    m_wel = 1'b0;
    status();
    check(active_mode, 8'h00);
  endtask : idle
  task automatic unlock();
    cmd(CMD_WRITE_UNLOCK, 24'h00_0000, 1);
    m_wel = 1'b1;
  endtask : unlock
  task automatic final_report();
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    #1_000_000;
    error_cnt++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    status();
    cmd(CMD_WRITE_UNLOCK, 24'h00_0000, 1, 0, 4);
    status();
    unlock();
    status();
    cmd(CMD_WRITE_STATUS, 24'h04_0000, 2);
    m_lvl = 3'h1;
    idle();
    host.mode3 = 1'b1;
    wp_n = 1'b0;
    unlock();
    cmd(CMD_REGION_CLEAR, 24'h1f_0000, 4);
    check(n_ops, 8'h00);
    status();
    cmd(CMD_PAGE_WRITE, 24'h00_0100, 4, 3);
    check({n_ops[5:0], k_last}, {6'h01, OP_PROGRAM});
    check(op_addr[15:8], 8'h01);
    idle();
    check(exp_q.size(), 8'h00);
    wp_n = 1'b1;
    host.mode3 = 1'b0;
    unlock();
    cmd(CMD_REGION_CLEAR, 24'h1f_0000, 4);
    check({n_ops[5:0], k_last}, {6'h02, OP_SECTOR});
    check(op_addr[20:16], 8'h1f);
    idle();
    unlock();
    cmd(CMD_WHOLE_ARRAY_CLEAR, 24'h00_0000, 1);
    check({n_ops[5:0], k_last}, {6'h03, OP_ARRAY});
    idle();
    cmd(CMD_DEEP_SLEEP, 24'h00_0000, 1);
    check(deep_sleep, 8'h01);
    unlock();
    cmd(CMD_WHOLE_ARRAY_CLEAR, 24'h00_0000, 1);
    check(n_ops, 8'h03);
    cmd(CMD_WAKE, 24'h00_0000, 1);
    check(deep_sleep, 8'h00);
    cmd(CMD_WRITE_LOCK, 24'h00_0000, 1);
    m_wel = 1'b0;
    status();
    final_report();
  end
endmodule : testbench
